// ===== logic/pst_timer.sv
// prescaled 8/16-bit tick counter with postscaler and bus registers
//
// Notes on behaviour
// [R1] a 3-bit field in config register b picks the count source
// [R2] internal source: count once per prescaled group of source periods
// [R3] external source: count on prescaled multiples of input rising edges
// [R4] prescaler offers sixteen power-of-two ratios, 1:1 to 1:32768
// [R5] prescale count hidden; low-byte or config-b write clears it
// [R6] postscaler ratio is code plus one, 1:1 to 1:16
// [R7] postscale count hidden; low-byte or control-a write clears it
// [R8] sleep with synchronised input stops the count
// [R9] sleep with bypassed sync keeps counting; enabled flag wakes device
// [R10] event: 8-bit low equals period copied from high byte, 16-bit wraps past FFFF
// [R11] flag sets once every postscale code plus one events
// [R12] flag with enable set raises the interrupt, also waking sleep
// [R13] pulse output high one prescaled period per postscaled event
// [R14] timer output toggles on each rising edge of the pulse
// [R15] timer output goes to pin routing and peripherals such as ADC
// [R16] control register a bit 5 shows the timer output level
// [R17] wide mode bit: 1 gives 16-bit, 0 gives 8-bit counting
// [R18] 8-bit match clears low byte, loads period from high byte
// [R19] 16-bit: low write loads true high, low read captures it
// [R20] sync bypass clear: resynchronise input; set: count edges directly
// [R21] prescale code n divides by two to the n
// [R22] run bit clear stops counting and idles the block
`default_nettype none
`include "pst_consts.svh"

module pst_timer (
	input  wire logic                   CLK_SYS,
	input  wire logic                   RST,
	input  wire logic                   SLEEP,
	input  wire logic                   EXT_CLK_IN,
	input  wire logic                   LC_CLK_IN,
	input  wire logic                   HF_CLK_IN,
	input  wire logic                   LF_CLK_IN,
	input  wire logic                   MF_CLK_IN,
	input  wire logic [`PST_ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic                   S_AXI_AWVALID,
	output logic                        S_AXI_AWREADY,
	input  wire logic [31:0]            S_AXI_WDATA,
	input  wire logic [3:0]             S_AXI_WSTRB,
	input  wire logic                   S_AXI_WVALID,
	output logic                        S_AXI_WREADY,
	output logic [1:0]                  S_AXI_BRESP,
	output logic                        S_AXI_BVALID,
	input  wire logic                   S_AXI_BREADY,
	input  wire logic [`PST_ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic                   S_AXI_ARVALID,
	output logic                        S_AXI_ARREADY,
	output logic [31:0]                 S_AXI_RDATA,
	output logic [1:0]                  S_AXI_RRESP,
	output logic                        S_AXI_RVALID,
	input  wire logic                   S_AXI_RREADY,
	output logic                        TIMER_OUT,
	output logic                        PULSE_OUT,
	output logic                        IRQ,
	output logic                        WAKE
);

	// register state
	pst_pkg::pst_ctrl_a_t       ctrl_a_reg;
	pst_pkg::pst_cfg_b_t        cfg_b_reg;
	pst_pkg::pst_irq_t          irq_reg;
	logic [7:0]                 cnt_lo_reg;
	logic [7:0]                 cnt_hi_reg;
	logic [7:0]                 hi_true_reg;
	logic [7:0]                 period_reg;
	logic [3:0]                 post_cnt_reg;
	logic                       pulse_reg;
	logic                       out_reg;

	// source path state
	logic                       sync1_reg;
	logic                       sync2_reg;
	logic                       prev_reg;

	// bus state
	logic                       aw_full_reg;
	logic [`PST_ADDR_W-1:0]     aw_addr_reg;
	logic                       w_full_reg;
	logic [7:0]                 w_data_reg;
	logic                       w_lane_reg;
	logic                       bvalid_reg;
	logic [1:0]                 bresp_reg;
	logic                       rvalid_reg;
	logic [1:0]                 rresp_reg;
	logic [31:0]                rdata_reg;

	// combinational nets
	pst_pkg::pst_src_t          src_sel;
	pst_pkg::pst_ctrl_a_t       ctrl_a_rd;
	logic                       src_level;
	logic                       src_chosen;
	logic                       src_edge;
	logic                       src_tick;
	logic                       halt;
	logic                       count_en;
	logic                       pre_in;
	logic                       pre_clr;
	logic                       pre_tick;
	logic                       wide;
	logic [15:0]                cnt16_inc;
	logic                       ev8;
	logic                       ev16;
	logic                       cnt_ev;
	logic                       post_hit;
	logic                       pulse_next;
	logic                       aw_take;
	logic                       w_take;
	logic                       wr_fire;
	logic [`PST_ADDR_W-1:0]     wr_addr;
	logic [7:0]                 wr_data;
	logic                       wr_lane;
	logic                       wr_lo;
	logic                       wr_hi;
	logic                       wr_ctrl;
	logic                       wr_cfg;
	logic                       wr_irq;
	logic                       wr_hit;
	logic                       ar_take;
	logic                       rd_lo;
	logic                       rd_hit;
	logic [7:0]                 rd_byte;

	// source selection from the select field
	assign src_sel = cfg_b_reg.src;
	assign src_level =
		(src_sel == pst_pkg::PST_SRC_EXT_TRUE) ? EXT_CLK_IN :
		(src_sel == pst_pkg::PST_SRC_EXT_INV)  ? ~EXT_CLK_IN :
		(src_sel == pst_pkg::PST_SRC_HF)       ? HF_CLK_IN :
		(src_sel == pst_pkg::PST_SRC_LF)       ? LF_CLK_IN :
		(src_sel == pst_pkg::PST_SRC_MF)       ? MF_CLK_IN :
		(src_sel == pst_pkg::PST_SRC_LC)       ? LC_CLK_IN :
		1'b0; // [R1]

	// resynchronised or direct source, then rising edge
	assign src_chosen = cfg_b_reg.bypass ? src_level : sync2_reg; // [R20]
	assign src_edge = src_chosen & ~prev_reg; // [R3]
	// instruction clock source ticks every cycle
	assign src_tick = (src_sel == pst_pkg::PST_SRC_FOSC4) | src_edge; // [R2]

	// sleep and run gating
	assign halt = SLEEP & ~cfg_b_reg.bypass; // [R8] [R9]
	assign count_en = ctrl_a_reg.run & ~halt; // [R22]
	assign pre_in = src_tick & count_en;
	assign pre_clr = wr_lo | wr_cfg | ~ctrl_a_reg.run; // [R5]

	// power-of-two prescaler
	pst_prescaler u_pre (
		.clk      (CLK_SYS),
		.rst      (RST),
		.clr      (pre_clr),
		.tick_in  (pre_in),
		.sel      (cfg_b_reg.pre_sel),
		.tick_out (pre_tick)
	);

	// counting events in both widths
	assign wide = ctrl_a_reg.wide; // [R17]
	assign cnt16_inc = {hi_true_reg, cnt_lo_reg} + `PST_CNT_ONE;
	assign ev8 = pre_tick & ~wide & (cnt_lo_reg == period_reg); // [R10]
	assign ev16 = pre_tick & wide & ({hi_true_reg, cnt_lo_reg} == `PST_CNT_FULL); // [R10]
	assign cnt_ev = ev8 | ev16;

	// postscaler: one hit every post_sel plus one events
	assign post_hit = cnt_ev & (post_cnt_reg == ctrl_a_reg.post_sel); // [R6] [R11]

	// pulse held until the next prescaled tick
	assign pulse_next = ~ctrl_a_reg.run ? 1'b0 :
		post_hit ? 1'b1 :
		pre_tick ? 1'b0 :
		pulse_reg; // [R13]

	// bus write channel
	assign aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
	assign w_take = S_AXI_WVALID & S_AXI_WREADY;
	assign wr_fire = (aw_full_reg | aw_take) & (w_full_reg | w_take);
	assign wr_addr = aw_full_reg ? aw_addr_reg : S_AXI_AWADDR;
	assign wr_data = w_full_reg ? w_data_reg : S_AXI_WDATA[7:0];
	assign wr_lane = w_full_reg ? w_lane_reg : S_AXI_WSTRB[0];

	// write decode, lane 0 carries every register
	assign wr_lo = wr_fire & wr_lane & (wr_addr == `PST_OFF_CNT_LO);
	assign wr_hi = wr_fire & wr_lane & (wr_addr == `PST_OFF_CNT_HI);
	assign wr_ctrl = wr_fire & wr_lane & (wr_addr == `PST_OFF_CTRL_A);
	assign wr_cfg = wr_fire & wr_lane & (wr_addr == `PST_OFF_CFG_B);
	assign wr_irq = wr_fire & wr_lane & (wr_addr == `PST_OFF_IRQ);
	assign wr_hit = (wr_addr == `PST_OFF_CNT_LO) | (wr_addr == `PST_OFF_CNT_HI) |
		(wr_addr == `PST_OFF_CTRL_A) | (wr_addr == `PST_OFF_CFG_B) |
		(wr_addr == `PST_OFF_IRQ);

	// bus read decode
	assign ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
	assign rd_lo = ar_take & (S_AXI_ARADDR == `PST_OFF_CNT_LO);
	assign ctrl_a_rd = '{run: ctrl_a_reg.run, rsvd: 1'b0, out_st: out_reg,
		wide: ctrl_a_reg.wide, post_sel: ctrl_a_reg.post_sel}; // [R16]
	assign rd_hit = (S_AXI_ARADDR == `PST_OFF_CNT_LO) |
		(S_AXI_ARADDR == `PST_OFF_CNT_HI) | (S_AXI_ARADDR == `PST_OFF_CTRL_A) |
		(S_AXI_ARADDR == `PST_OFF_CFG_B) | (S_AXI_ARADDR == `PST_OFF_IRQ);
	assign rd_byte =
		(S_AXI_ARADDR == `PST_OFF_CNT_LO) ? cnt_lo_reg :
		(S_AXI_ARADDR == `PST_OFF_CNT_HI) ? cnt_hi_reg :
		(S_AXI_ARADDR == `PST_OFF_CTRL_A) ? ctrl_a_rd :
		(S_AXI_ARADDR == `PST_OFF_CFG_B)  ? cfg_b_reg :
		(S_AXI_ARADDR == `PST_OFF_IRQ)    ? irq_reg :
		8'h00;

	// bus handshakes: one write and one read in flight
	assign S_AXI_AWREADY = ~aw_full_reg & ~bvalid_reg;
	assign S_AXI_WREADY = ~w_full_reg & ~bvalid_reg;
	assign S_AXI_BVALID = bvalid_reg;
	assign S_AXI_BRESP = bresp_reg;
	assign S_AXI_ARREADY = ~rvalid_reg;
	assign S_AXI_RVALID = rvalid_reg;
	assign S_AXI_RRESP = rresp_reg;
	assign S_AXI_RDATA = rdata_reg;

	// timer outputs, also the ADC auto-conversion trigger
	assign TIMER_OUT = out_reg; // [R15]
	assign PULSE_OUT = pulse_reg;
	assign IRQ = irq_reg.flag & irq_reg.irq_en; // [R12]
	assign WAKE = IRQ & SLEEP; // [R9] [R12]

	// two-flop synchroniser and edge history
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg <= 1'b0;
		end
		else
		begin
			sync1_reg <= src_level;
			sync2_reg <= sync1_reg; // [R20]
			prev_reg <= src_chosen;
		end
	end

	// control and configuration registers
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			ctrl_a_reg <= `PST_RST_CTRL_A;
			cfg_b_reg <= `PST_RST_CFG_B;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_a_reg <= wr_data
					& `PST_CTRL_A_WMASK; // status and spare bits stay clear
			if (wr_cfg)
				cfg_b_reg <= wr_data; // [R1]
		end
	end

	// low byte: write, match clear or increment
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			cnt_lo_reg <= `PST_RST_CNT_LO;
		else if (wr_lo)
			cnt_lo_reg <= wr_data;
		else if (ev8)
			cnt_lo_reg <= `PST_RST_CNT_LO; // [R18]
		else if (pre_tick)
			cnt_lo_reg <= cnt16_inc[7:0]; // [R2] [R3]
	end

	// hidden true high byte of the 16-bit count
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			hi_true_reg <= `PST_RST_HI_TRUE;
		else if (wr_lo & wide)
			hi_true_reg <= cnt_hi_reg; // [R19]
		else if (pre_tick & wide)
			hi_true_reg <= cnt16_inc[15:8];
	end

	// high byte buffer and 8-bit period copy
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			cnt_hi_reg <= `PST_RST_CNT_HI;
			period_reg <= `PST_RST_CNT_HI;
		end
		else
		begin
			if (wr_hi)
				cnt_hi_reg <= wr_data;
			else if (rd_lo & wide)
				cnt_hi_reg <= hi_true_reg; // [R19]
			if (ev8)
				period_reg <= cnt_hi_reg; // [R18]
		end
	end

	// postscale count, hidden from software
	always_ff @(posedge CLK_SYS)
	begin
		if (RST | wr_lo | wr_ctrl)
			post_cnt_reg <= `PST_RST_POST; // [R7]
		else if (post_hit)
			post_cnt_reg <= `PST_RST_POST; // [R6]
		else if (cnt_ev)
			post_cnt_reg <= post_cnt_reg + `PST_POST_ONE;
	end

	// pulse and toggled output
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			pulse_reg <= 1'b0;
			out_reg <= 1'b0;
		end
		else
		begin
			pulse_reg <= pulse_next; // [R13]
			out_reg <= out_reg ^ (pulse_next & ~pulse_reg); // [R14]
		end
	end

	// flag set beats a same-cycle clear; enable is plain storage
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			irq_reg <= '0;
		else
		begin
			if (post_hit)
				irq_reg.flag <= 1'b1; // [R11]
			else if (wr_irq & wr_data[`PST_BIT_FLAG])
				irq_reg.flag <= 1'b0;
			if (wr_irq)
				irq_reg.irq_en <= wr_data[`PST_BIT_IRQ_EN];
		end
	end

	// write address and data holding
	always_ff @(posedge CLK_SYS)
	begin
		if (RST | wr_fire)
		begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
		end
		else
		begin
			if (aw_take)
				aw_full_reg <= 1'b1;
			if (w_take)
				w_full_reg <= 1'b1;
		end
	end

	// holding payloads, no reset needed for data
	always_ff @(posedge CLK_SYS)
	begin
		if (aw_take)
			aw_addr_reg <= S_AXI_AWADDR;
		if (w_take)
		begin
			w_data_reg <= S_AXI_WDATA[7:0];
			w_lane_reg <= S_AXI_WSTRB[0];
		end
	end

	// write response
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg <= `PST_RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_hit ? `PST_RESP_OKAY : `PST_RESP_DECERR;
		end
		else if (S_AXI_BREADY)
			bvalid_reg <= 1'b0;
	end

	// read response
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			rvalid_reg <= 1'b0;
			rresp_reg <= `PST_RESP_OKAY;
			rdata_reg <= '0;
		end
		else if (ar_take)
		begin
			rvalid_reg <= 1'b1;
			rresp_reg <= rd_hit ? `PST_RESP_OKAY : `PST_RESP_DECERR;
			rdata_reg <= {`PST_RD_PAD, rd_byte};
		end
		else if (S_AXI_RREADY)
			rvalid_reg <= 1'b0;
	end

endmodule : pst_timer

`default_nettype wire

// ===== logic/pst_consts.svh
// constants for the prescaled tick counter: offsets, resets, codes
`ifndef PST_CONSTS_SVH
`define PST_CONSTS_SVH

// register byte addresses on the bus
`define PST_OFF_CNT_LO  8'h00
`define PST_OFF_CNT_HI  8'h04
`define PST_OFF_CTRL_A  8'h08
`define PST_OFF_CFG_B   8'h0C
`define PST_OFF_IRQ     8'h10

// reset values
`define PST_RST_CNT_LO  8'h00
`define PST_RST_CNT_HI  8'hFF
`define PST_RST_CTRL_A  8'h00
`define PST_RST_CFG_B   8'h00
`define PST_RST_HI_TRUE 8'h00
`define PST_RST_POST    4'h0

// writable bits of control a, bit places of the flag register
`define PST_CTRL_A_WMASK 8'h9F
`define PST_BIT_FLAG     0
`define PST_BIT_IRQ_EN   1

// counter limits and steps
`define PST_CNT_FULL    16'hFFFF
`define PST_CNT_ONE     16'h0001
`define PST_POST_ONE    4'h1
`define PST_PRE_W       15
`define PST_PRE_ZERO    15'h0000
`define PST_PRE_ONE     15'h0001

// bus widths and answers
`define PST_ADDR_W      8
`define PST_RESP_OKAY   2'b00
`define PST_RESP_DECERR 2'b11
`define PST_RD_PAD      24'h000000

`endif

// ===== logic/pst_pkg.sv
// types shared by the prescaled tick counter files
`default_nettype none

package pst_pkg;

	// clock source codes of the source select field
	typedef enum logic [2:0] {
		PST_SRC_EXT_TRUE = 3'b000,
		PST_SRC_EXT_INV  = 3'b001,
		PST_SRC_FOSC4    = 3'b010,
		PST_SRC_HF       = 3'b011,
		PST_SRC_LF       = 3'b100,
		PST_SRC_MF       = 3'b101,
		PST_SRC_RSVD     = 3'b110,
		PST_SRC_LC       = 3'b111
	} pst_src_t;

	// control register a layout
	typedef struct packed {
		logic       run;
		logic       rsvd;
		logic       out_st;
		logic       wide;
		logic [3:0] post_sel;
	} pst_ctrl_a_t;

	// configuration register b layout
	typedef struct packed {
		pst_src_t   src;
		logic       bypass;
		logic [3:0] pre_sel;
	} pst_cfg_b_t;

	// flag and enable register layout
	typedef struct packed {
		logic [5:0] zero;
		logic       irq_en;
		logic       flag;
	} pst_irq_t;

endpackage : pst_pkg

`default_nettype wire

// ===== logic/pst_prescaler.sv
// power-of-two prescaler, ratio 1:2^sel
`default_nettype none
`include "pst_consts.svh"

module pst_prescaler (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       clr,
	input  wire logic       tick_in,
	input  wire logic [3:0] sel,
	output logic            tick_out
);

	logic [`PST_PRE_W-1:0] cnt_reg;
	logic [`PST_PRE_W-1:0] cnt_next;
	logic [`PST_PRE_W-1:0] mask;

	// low sel bits of the count must all be ones to pass a tick
	for (genvar g = 0; g < `PST_PRE_W; g++)
	begin : g_mask
		assign mask[g] = (sel > 4'(g));
	end

	assign tick_out = tick_in & ((cnt_reg & mask) == mask); // [R21]
	assign cnt_next = tick_out ? `PST_PRE_ZERO : cnt_reg + `PST_PRE_ONE;

	// count is hidden from software, cleared on request
	always_ff @(posedge clk)
	begin
		if (rst | clr)
			cnt_reg <= `PST_PRE_ZERO; // [R5]
		else if (tick_in)
			cnt_reg <= cnt_next; // [R4]
	end

endmodule : pst_prescaler

`default_nettype wire

// ===== test/pst_timer_sva.sv
// assertion checker on the tick counter ports
`default_nettype none

module pst_timer_sva (
	input wire logic        CLK_SYS,
	input wire logic        RST,
	input wire logic        SLEEP,
	input wire logic        S_AXI_AWREADY,
	input wire logic        S_AXI_WREADY,
	input wire logic [1:0]  S_AXI_BRESP,
	input wire logic        S_AXI_BVALID,
	input wire logic        S_AXI_BREADY,
	input wire logic        S_AXI_ARVALID,
	input wire logic        S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic        S_AXI_RVALID,
	input wire logic        S_AXI_RREADY,
	input wire logic        TIMER_OUT,
	input wire logic        PULSE_OUT,
	input wire logic        IRQ,
	input wire logic        WAKE
);
	// one clock domain for every property
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	a_wake_irq_sleep: assert property (WAKE == (IRQ && SLEEP))
		else $error("wake differs from irq and sleep");
	a_toggle_on_pulse: assert property ($rose(PULSE_OUT) |-> TIMER_OUT != $past(TIMER_OUT))
		else $error("timer output missed a toggle");
	a_toggle_only_pulse: assert property ($changed(TIMER_OUT) |-> $rose(PULSE_OUT))
		else $error("timer output toggled without pulse");
	a_bresp_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped early");
	a_rdata_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped early");
	a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	a_write_blocked: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write taken during response");
	a_read_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read taken during response");
	a_rdata_upper_zero: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
endmodule : pst_timer_sva

bind pst_timer pst_timer_sva pst_timer_sva_inst (.CLK_SYS, .RST, .SLEEP, .S_AXI_AWREADY,
	.S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY,
	.S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .TIMER_OUT, .PULSE_OUT, .IRQ, .WAKE);

`default_nettype wire

// ===== test/pst_timer_tb.sv
// self-checking bench for the prescaled tick counter
`default_nettype none
`include "pst_consts.svh"

module pst_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] a_lo = `PST_OFF_CNT_LO;
	localparam logic [7:0] a_hi = `PST_OFF_CNT_HI;
	localparam logic [7:0] a_ca = `PST_OFF_CTRL_A;
	localparam logic [7:0] a_cb = `PST_OFF_CFG_B;
	localparam logic [7:0] a_ir = `PST_OFF_IRQ;
	logic        clk = 1'b0, rst = 1'b1, sleep = 1'b0, src_in = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h00000000, rdata, cd;
	logic [3:0]  wstrb = 4'h0;
	logic [1:0]  bresp, rresp, cb, cr;
	logic        awready, wready, bvalid, arready, rvalid, tmr_out, pulse, irq, wake;
	logic [3:0]  pre_t [4] = '{4'h0, 4'h2, 4'h0, 4'h4};
	logic [3:0]  post_t [4] = '{4'h0, 4'h0, 4'hF, 4'h1};
	int          ex_t [4] = '{4, 16, 64, 128};
	int          n_mismatch = 0, total_checks = 0, g;
	logic [7:0]  k;

	// clock at 125 MHz
	always #4 clk = ~clk;

	pst_timer pst_timer_inst (.CLK_SYS(clk), .RST(rst), .SLEEP(sleep), .EXT_CLK_IN(src_in),
		.LC_CLK_IN(src_in), .HF_CLK_IN(src_in), .LF_CLK_IN(src_in), .MF_CLK_IN(src_in),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.TIMER_OUT(tmr_out), .PULSE_OUT(pulse), .IRQ(irq), .WAKE(wake));

	// compare and count
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// wait at falling edges for a handshake, return after the taking edge
	task automatic hs(input int w);
		int n;
		logic h;
		n = 0;
		do
		begin
			@(negedge clk);
			h = (w == 0) ? awready && wready : (w == 1) ? bvalid : (w == 2) ? arready : rvalid;
			cb = bresp;
			cr = rresp;
			cd = rdata;
			n++;
		end while (h !== 1'b1 && n < 100);
		if (n >= 100)
			chk("handshake", 32'h1, 32'h0);
		@(posedge clk);
	endtask : hs

	// bus write, late bready so the response waits one cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
		awaddr <= a;
		wdata <= {24'h000000, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		hs(0);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		hs(1);
		bready <= 1'b1;
		@(posedge clk);
		bready <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic w(input logic [7:0] a, input logic [7:0] d);
		wr(a, d, 4'h1);
	endtask : w

	// bus read into cd and cr
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		hs(2);
		arvalid <= 1'b0;
		hs(3);
		rready <= 1'b1;
		@(posedge clk);
		rready <= 1'b0;
		@(posedge clk);
	endtask : rd

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk("rdata", {24'h000000, e}, cd);
		chk("rresp", {30'h0, `PST_RESP_OKAY}, {30'h0, cr});
	endtask : rc

	// cycles until the next rising pulse, minus one
	task automatic rise(output int n);
		logic p;
		n = 0;
		p = 1'b1;
		@(negedge clk);
		while (!(pulse === 1'b1 && p === 1'b0) && n < 5000)
		begin
			p = pulse;
			n++;
			@(negedge clk);
		end
		@(posedge clk);
	endtask : rise

	// reset values, unmapped place, masked write
	task automatic t_reset;
		rc(a_lo, `PST_RST_CNT_LO);
		rc(a_hi, `PST_RST_CNT_HI);
		rc(a_ca, `PST_RST_CTRL_A);
		rc(a_cb, `PST_RST_CFG_B);
		rc(a_ir, 8'h00);
		rd(8'h14);
		chk("unmapped rresp", {30'h0, `PST_RESP_DECERR}, {30'h0, cr});
		chk("unmapped rdata", 32'h0, cd);
		wr(8'h14, 8'h55, 4'h1);
		chk("unmapped bresp", {30'h0, `PST_RESP_DECERR}, {30'h0, cb});
		wr(a_hi, 8'h55, 4'h0);
		rc(a_hi, 8'hFF);
		$display("test reset done");
	endtask : t_reset

	// 8-bit match, postscale 1:3, flag, irq, stop
	task automatic t_match;
		w(a_cb, 8'h40);
		w(a_hi, 8'h03);
		w(a_ca, 8'h82);
		rise(g);
		k[0] = tmr_out;
		rise(g);
		chk("match gap", 32'd12, g + 1);
		chk("toggle", {31'h0, ~k[0]}, {31'h0, tmr_out});
		rc(a_ir, 8'h01);
		w(a_ir, 8'h02);
		chk("irq", 32'h1, {31'h0, irq});
		w(a_ir, 8'h01);
		chk("irq off", 32'h0, {31'h0, irq});
		w(a_ca, 8'h02);
		rd(a_ca);
		chk("out bit", {24'h0, 2'b00, tmr_out, 5'h02}, cd);
		rd(a_lo);
		k = cd[7:0];
		rc(a_lo, k);
		$display("test match done");
	endtask : t_match

	// prescale and postscale ratios
	task automatic t_ratio;
		for (int i = 0; i < 4; i++)
		begin
			w(a_cb, {4'h4, pre_t[i]});
			w(a_ca, {4'h8, post_t[i]});
			rise(g);
			rise(g);
			chk("ratio gap", ex_t[i], g + 1);
		end
		$display("test ratio done");
	endtask : t_ratio

	// 16-bit buffered high byte, wrap, sleep
	task automatic t_wide;
		w(a_ca, 8'h10);
		w(a_hi, 8'h12);
		w(a_lo, 8'h34);
		w(a_hi, 8'h99);
		rc(a_lo, 8'h34);
		rc(a_hi, 8'h12);
		w(a_hi, 8'hFF);
		w(a_lo, 8'h00);
		w(a_cb, 8'h40);
		w(a_ca, 8'h90);
		rise(g);
		chk("wrap", 32'h1, {31'h0, g > 240 && g < 260});
		sleep <= 1'b1;
		rd(a_lo);
		k = cd[7:0];
		rc(a_lo, k);
		w(a_cb, 8'h50);
		rd(a_lo);
		k = cd[7:0];
		rd(a_lo);
		chk("async run", 32'h1, {31'h0, cd[7:0] != k});
		w(a_ir, 8'h02);
		chk("wake", 32'h1, {31'h0, wake});
		sleep <= 1'b0;
		w(a_ir, 8'h01);
		$display("test wide done");
	endtask : t_wide

	// each clock source code counts five input edges; instruction clock code unchecked, reserved code counts none
	task automatic t_src;
		for (int c = 0; c < 8; c++)
		begin
			w(a_ca, 8'h10);
			w(a_cb, {3'(c), c[0], 4'h0});
			w(a_hi, 8'h00);
			w(a_lo, 8'h00);
			w(a_ca, 8'h90);
			repeat (10)
			begin
				src_in <= ~src_in;
				repeat (2) @(posedge clk);
			end
			w(a_ca, 8'h10);
			rd(a_lo);
			if (c != 2)
				chk("source count", (c == 6) ? 32'h0 : 32'h5, cd);
		end
		$display("test source done");
	endtask : t_src

	// reset in mid-run brings registers and outputs back
	task automatic t_rerst;
		w(a_cb, 8'h40);
		w(a_hi, 8'h01);
		w(a_ca, 8'h80);
		repeat (600) @(posedge clk);
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("pulse reset", 32'h0, {31'h0, pulse});
		chk("out reset", 32'h0, {31'h0, tmr_out});
		rc(a_ca, `PST_RST_CTRL_A);
		rc(a_cb, `PST_RST_CFG_B);
		rc(a_hi, `PST_RST_CNT_HI);
		rc(a_ir, 8'h00);
		rc(a_lo, `PST_RST_CNT_LO);
		$display("test mid-run reset done");
	endtask : t_rerst

	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	// main sequence
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_match();
		t_ratio();
		t_wide();
		t_src();
		t_rerst();
		summarize();
	end

	// watchdog
	initial
	begin
		#200000;
		n_mismatch++;
		summarize();
	end
endmodule : pst_timer_tb

`default_nettype wire
